// *** bench/tcg_host_model.sv ***
// Purpose: host side of the capture store, manual and automatic readout
// Assumes: requests change 1 ns after the rising edge of mclk
// Notes: automatic mode requests every other cycle so the count settles
`timescale 1ns/1ns
`default_nettype none
module tcg_host_model (
    // clock
    input wire logic mclk,
    // store status
    input wire logic autoReadout,
    input wire logic [tcg_pkg::PTR_W-1:0] entryCount_reg,
    input wire logic readValid_reg,
    input wire logic [tcg_pkg::ENTRY_W-1:0] readData_reg,
    // host requests
    output logic readReq,
    output logic clearCmd
);
    int nRead = 0;
    logic autoReq, popReq;
    // one driver for the request line: streaming and single pulls merge here
    assign readReq = autoReq | popReq;
    initial begin
        autoReq = 1'h0;
        popReq = 1'h0;
        clearCmd = 1'h0;
    end
    // every entry handed over, manual or automatic
    always @(posedge mclk) if (readValid_reg) nRead <= nRead + 1;
    // streaming readout while automatic mode is on
    always @(posedge mclk) begin
        #1;
        autoReq = autoReadout && !autoReq && entryCount_reg != 10'h000;
    end
    // one pull; the answer stands in the cycle after the request is taken
    task automatic pop(output logic [tcg_pkg::ENTRY_W-1:0] data, output logic ok);
        @(posedge mclk) #1 popReq = 1'h1;
        @(posedge mclk) #1 popReq = 1'h0;
        ok = readValid_reg;
        data = readData_reg;
    endtask
    // one clear pulse; the store ignores it while automatic readout is on
    task automatic clear;
        @(posedge mclk) #1 clearCmd = 1'h1;
        @(posedge mclk) #1 clearCmd = 1'h0;
    endtask
endmodule
`default_nettype wire

// *** bench/tcg_output_gate_tb_top.sv ***
// Purpose: self-checking bench for the output gate and capture store
// Assumes: 100 MHz mclk, inputs driven 1 ns after the rising edge
// Notes: stamps are held steady across each capture pulse
`timescale 1ns/1ns
`default_nettype none
module tcg_output_gate_tb_top;
    logic mclk, rst_n, localTimeSel, forceSync, enableAfterSync, autoReadout, codeBit;
    logic decoderSyncPin, captureChannelZeroPin, readReq, clearCmd, ok;
    logic [3:0] ppFuncSel, tfomIn, codeTfom_reg;
    logic [1:0] pulseIn, programmablePulseConnector_reg;
    logic [63:0] timeUtc, timeLocal, codeTime_reg, t;
    logic levelShiftOut_reg, modulatedOut_reg, outputsEnabled_reg, readValid_reg, overflow_reg;
    logic [64:0] readData_reg, d;
    logic [9:0] entryCount_reg, entryCapacity_reg;
    logic [63:0] q[$];
    int failures = 0, nCompared = 0, seed = 48780, n0;
    tcg_output_gate dut (.mclk, .rst_n, .localTimeSel, .forceSync, .enableAfterSync,
        .ppFuncSel, .autoReadout, .codeBit, .timeUtc, .timeLocal, .tfomIn, .pulseIn,
        .decoderSyncPin, .captureChannelZeroPin, .clearCmd, .readReq, .levelShiftOut_reg,
        .modulatedOut_reg, .codeTime_reg, .codeTfom_reg, .programmablePulseConnector_reg,
        .outputsEnabled_reg, .readData_reg, .readValid_reg, .entryCount_reg,
        .entryCapacity_reg, .overflow_reg);
    tcg_host_model host (.mclk, .autoReadout, .entryCount_reg, .readValid_reg,
        .readData_reg, .readReq, .clearCmd);
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // hang guard, far above the longest sequence
    initial begin
        #200000;
        failures++;
        give_verdict;
    end
    task automatic chk(input logic [64:0] got, input logic [64:0] exp);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge mclk) #1;
    endtask
    task automatic do_reset(input logic afterSync);
        rst_n = 1'h0;
        enableAfterSync = afterSync;
        repeat (2) step;
        chk({entryCapacity_reg, entryCount_reg}, {tcg_pkg::CAPACITY, 10'h000});
        rst_n = 1'h1;
    endtask
    task automatic rnd;
        {codeBit, localTimeSel, forceSync, pulseIn, ppFuncSel, tfomIn} = 13'($random(seed));
        timeUtc = {$random(seed), $random(seed)};
        timeLocal = {$random(seed), $random(seed)};
    endtask
    // expected programmable output; function 3 shows the sync state
    function automatic logic ppExp(input int i);
        case (ppFuncSel[2*i+:2])
            2'h0: return 1'h0;
            2'h1: return codeBit;
            2'h2: return pulseIn[i];
            default: return decoderSyncPin;
        endcase
    endfunction
    task automatic chk_code;
        chk({levelShiftOut_reg, modulatedOut_reg}, {2{codeBit}});
        chk(codeTime_reg, localTimeSel ? timeLocal : timeUtc);
        chk(codeTfom_reg, forceSync ? tcg_pkg::TFOM_SYNC : tfomIn);
        chk(programmablePulseConnector_reg, {ppExp(1), ppExp(0)});
    endtask
    // one capture pulse, two cycles high and two low
    task automatic event_at(input logic [63:0] stamp);
        timeUtc = stamp;
        captureChannelZeroPin = 1'h1;
        repeat (2) step;
        captureChannelZeroPin = 1'h0;
        repeat (2) step;
    endtask
    task automatic give_verdict;
        $display("compared %0d failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {localTimeSel, forceSync, autoReadout, codeBit, decoderSyncPin} = 5'h00;
        {captureChannelZeroPin, ppFuncSel, tfomIn, pulseIn, timeUtc, timeLocal} = '0;
        do_reset(1'h1);
        repeat (20) begin
            rnd;
            step;
            chk({outputsEnabled_reg, levelShiftOut_reg, modulatedOut_reg,
                programmablePulseConnector_reg}, 5'h00);
        end
        decoderSyncPin = 1'h1;
        for (int i = 0; i < 6 && outputsEnabled_reg !== 1'h1; i++) step;
        chk(outputsEnabled_reg, 1'h1);
        repeat (200) begin
            rnd;
            step;
            chk_code;
        end
        $display("test gate after sync done");
        decoderSyncPin = 1'h0;
        do_reset(1'h0);
        step;
        chk(outputsEnabled_reg, 1'h1);
        repeat (100) begin
            rnd;
            step;
            chk_code;
        end
        $display("test gate always done");
        repeat (40) begin
            t = {$random(seed), $random(seed)};
            event_at(t);
            q.push_back(t);
        end
        chk(entryCount_reg, 10'h028);
        while (q.size() > 0) begin
            host.pop(d, ok);
            chk(ok, 1'h1);
            chk(d, {tcg_pkg::CHAN_ZERO, q.pop_front()});
            chk(entryCount_reg, 10'(q.size()));
        end
        host.pop(d, ok);
        chk(ok, 1'h0);
        $display("test capture order done");
        repeat (584) event_at({$random(seed), $random(seed)});
        chk({entryCount_reg, overflow_reg}, {tcg_pkg::CAPACITY, 1'h1});
        host.clear;
        chk({entryCount_reg, overflow_reg}, 11'h000);
        $display("test fill and clear done");
        n0 = host.nRead;
        repeat (2) event_at({$random(seed), $random(seed)});
        chk(entryCount_reg, 10'h002);
        autoReadout = 1'h1;
        // the clear lands in a gap of the streaming reads and must be ignored
        step;
        host.clear;
        repeat (5) event_at({$random(seed), $random(seed)});
        repeat (4) step;
        chk(entryCount_reg, 10'h000);
        chk(32'(host.nRead - n0), 32'h7);
        autoReadout = 1'h0;
        $display("test automatic readout done");
        give_verdict;
    end
endmodule
`default_nettype wire

// *** hw/tcg_output_gate.sv ***
// Purpose: gate time code outputs and store captured events
// Assumes: code bit, times and pulses come from logic on mclk
// Notes: sync and capture inputs are pins and are double-registered
`timescale 1ns/1ns
`default_nettype none
module tcg_output_gate (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration
    input wire logic localTimeSel,
    input wire logic forceSync,
    input wire logic enableAfterSync,
    input wire logic [3:0] ppFuncSel,
    input wire logic autoReadout,
    // time code source
    input wire logic codeBit,
    input wire logic [tcg_pkg::TIME_W-1:0] timeUtc,
    input wire logic [tcg_pkg::TIME_W-1:0] timeLocal,
    input wire logic [tcg_pkg::TFOM_W-1:0] tfomIn,
    input wire logic [1:0] pulseIn,
    // pins from outside
    input wire logic decoderSyncPin,
    input wire logic captureChannelZeroPin,
    // host requests
    input wire logic clearCmd,
    input wire logic readReq,
    // time code outputs
    output logic levelShiftOut_reg,
    output logic modulatedOut_reg,
    output logic [tcg_pkg::TIME_W-1:0] codeTime_reg,
    output logic [tcg_pkg::TFOM_W-1:0] codeTfom_reg,
    output logic [1:0] programmablePulseConnector_reg,
    output logic outputsEnabled_reg,
    // capture store
    output logic [tcg_pkg::ENTRY_W-1:0] readData_reg,
    output logic readValid_reg,
    output logic [tcg_pkg::PTR_W-1:0] entryCount_reg,
    output logic [tcg_pkg::PTR_W-1:0] entryCapacity_reg,
    output logic overflow_reg
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic syncMeta_reg, syncSafe_reg, capMeta_reg, capSafe_reg, capLast_reg;
    logic syncSeen_reg, syncSeen_next;

    // two stages each; only the second stage is read below
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta_reg <= 1'b0;
            syncSafe_reg <= 1'b0;
            capMeta_reg <= 1'b0;
            capSafe_reg <= 1'b0;
            capLast_reg <= 1'b0;
        end else begin
            syncMeta_reg <= decoderSyncPin;
            syncSafe_reg <= syncMeta_reg;
            capMeta_reg <= captureChannelZeroPin;
            capSafe_reg <= capMeta_reg;
            capLast_reg <= capSafe_reg;
        end
    end

    wire logic capEvent = capSafe_reg & ~capLast_reg;

    // ----------------------------------------------------------------
    // output gating and code content
    // ----------------------------------------------------------------
    logic lsNext, amNext, enNext;
    logic [tcg_pkg::TIME_W-1:0] timeNext;
    logic [tcg_pkg::TFOM_W-1:0] tfomNext;
    logic [1:0] ppNext;

    // first sync is sticky until reset, so a later loss keeps outputs on
    always_comb begin
        syncSeen_next = syncSeen_reg | syncSafe_reg;
        enNext = !enableAfterSync || syncSeen_next;
        timeNext = localTimeSel ? timeLocal : timeUtc;
        tfomNext = forceSync ? tcg_pkg::TFOM_SYNC : tfomIn;
        lsNext = enNext & codeBit;
        amNext = enNext & codeBit;
        for (int i = 0; i < tcg_pkg::NUM_PP; i++) begin
            case (tcg_pkg::tcg_ppfunc_type'(ppFuncSel[2*i +: 2]))
                tcg_pkg::PP_CODE: ppNext[i] = enNext & codeBit;
                tcg_pkg::PP_PULSE: ppNext[i] = enNext & pulseIn[i];
                tcg_pkg::PP_SYNC: ppNext[i] = enNext & syncSafe_reg;
                default: ppNext[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syncSeen_reg <= 1'b0;
            outputsEnabled_reg <= 1'b0;
            levelShiftOut_reg <= 1'b0;
            modulatedOut_reg <= 1'b0;
            codeTime_reg <= '0;
            codeTfom_reg <= tcg_pkg::TFOM_SYNC;
            programmablePulseConnector_reg <= 2'h0;
        end else begin
            syncSeen_reg <= syncSeen_next;
            outputsEnabled_reg <= enNext;
            levelShiftOut_reg <= lsNext;
            modulatedOut_reg <= amNext;
            codeTime_reg <= timeNext;
            codeTfom_reg <= tfomNext;
            programmablePulseConnector_reg <= ppNext;
        end
    end

    // ----------------------------------------------------------------
    // capture store
    // ----------------------------------------------------------------
    logic [tcg_pkg::ENTRY_W-1:0] store [0:tcg_pkg::FIFO_DEPTH-1];
    logic [tcg_pkg::PTR_W-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [tcg_pkg::PTR_W-1:0] count_next;
    logic [tcg_pkg::ENTRY_W-1:0] rdData_next;
    logic rdValid_next, ovf_next, doWrite, doRead, doClear;

    // a clear drops everything, including an event in the same cycle;
    // in automatic mode reads still drain, so the host streams entries
    always_comb begin
        doClear = clearCmd & ~autoReadout;
        doRead = readReq & (entryCount_reg != tcg_pkg::PTR_ZERO) & ~doClear;
        doWrite = capEvent & ~doClear &
                  ((entryCount_reg != tcg_pkg::CAPACITY) | doRead);
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = entryCount_reg;
        rdData_next = readData_reg;
        rdValid_next = doRead;
        ovf_next = overflow_reg | (capEvent & ~doClear & ~doWrite);
        if (doClear) begin
            wrPtr_next = tcg_pkg::PTR_ZERO;
            rdPtr_next = tcg_pkg::PTR_ZERO;
            count_next = tcg_pkg::PTR_ZERO;
            ovf_next = 1'b0;
        end else begin
            if (doWrite) begin
                wrPtr_next = (wrPtr_reg == tcg_pkg::PTR_LAST) ? tcg_pkg::PTR_ZERO
                                                                : wrPtr_reg + 10'h001;
            end
            if (doRead) begin
                rdData_next = store[rdPtr_reg];
                rdPtr_next = (rdPtr_reg == tcg_pkg::PTR_LAST) ? tcg_pkg::PTR_ZERO
                                                                : rdPtr_reg + 10'h001;
            end
            if (doWrite && !doRead) begin
                count_next = entryCount_reg + 10'h001;
            end else if (doRead && !doWrite) begin
                count_next = entryCount_reg - 10'h001;
            end
        end
    end

    // entry is channel tag over the selected-free UTC time stamp
    always_ff @(posedge mclk) begin
        if (doWrite) begin
            store[wrPtr_reg] <= {tcg_pkg::CHAN_ZERO, timeUtc};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_reg <= tcg_pkg::PTR_ZERO;
            rdPtr_reg <= tcg_pkg::PTR_ZERO;
            entryCount_reg <= tcg_pkg::PTR_ZERO;
            entryCapacity_reg <= tcg_pkg::CAPACITY;
            readData_reg <= '0;
            readValid_reg <= 1'b0;
            overflow_reg <= 1'b0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            entryCount_reg <= count_next;
            entryCapacity_reg <= tcg_pkg::CAPACITY;
            readData_reg <= rdData_next;
            readValid_reg <= rdValid_next;
            overflow_reg <= ovf_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    same_format_a: assert property (levelShiftOut_reg == modulatedOut_reg)
        else $error("code outputs differ");
    pp_code_a: assert property (ppFuncSel[1:0] == 2'h1 |=>
        programmablePulseConnector_reg[0] == $past(lsNext))
        else $error("programmable output lost code");
    time_sel_a: assert property (localTimeSel |=> codeTime_reg == $past(timeLocal))
        else $error("local time not selected");
    force_sync_a: assert property (forceSync |=> codeTfom_reg == 4'h0)
        else $error("quality not forced to sync");
    hold_off_a: assert property (enableAfterSync && !syncSeen_reg && !syncSafe_reg
        |=> !levelShiftOut_reg && programmablePulseConnector_reg == 2'h0)
        else $error("output before first sync");
    always_on_a: assert property (!enableAfterSync |=> outputsEnabled_reg)
        else $error("outputs held in always mode");
    count_bound_a: assert property (entryCount_reg <= 10'h247)
        else $error("store over capacity");
    clear_empty_a: assert property (clearCmd && !autoReadout
        |=> entryCount_reg == 10'h000 && !overflow_reg)
        else $error("clear did not empty");
    auto_noclear_a: assert property (clearCmd && autoReadout && !readReq && !capEvent
        |=> $stable(entryCount_reg))
        else $error("clear acted in auto mode");
    read_pop_a: assert property (readReq && !clearCmd && entryCount_reg != 10'h000
        && !capEvent |=> readValid_reg && entryCount_reg == $past(entryCount_reg) - 10'h001)
        else $error("read did not pop");
    capture_push_a: assert property (capEvent && !clearCmd && !readReq
        && entryCount_reg < 10'h247 |=> entryCount_reg == $past(entryCount_reg) + 10'h001)
        else $error("event not stored");

    cover_sync_c: cover property (enableAfterSync ##1 syncSafe_reg ##1 outputsEnabled_reg);
    cover_full_c: cover property (entryCount_reg == 10'h247 && capEvent);
    cover_read_c: cover property (readValid_reg ##1 readValid_reg);
    cover_clear_c: cover property (clearCmd && !autoReadout && entryCount_reg != 10'h000);
endmodule
`default_nettype wire

// *** hw/tcg_pkg.sv ***
// Purpose: constants for the time code output gate and capture store
// Assumes: one 100 MHz clock, asynchronous active-low reset
// Notes: encoder, decoder and timezone logic live outside this block
//
// Summary of operation
// - same code format drives level-shift and modulated outputs together.
// - level-shift code may be routed to a programmable output by config.
// - config chooses UTC or timezone-converted local time for the code.
// - force-sync makes time figure-of-merit zero, IEEE formats only.
// - after-sync mode holds code and pulse outputs off until first sync.
// - always mode drives code and pulse outputs from reset onward.
// - two programmable outputs, each with its own function select.
// - each capture event stored with date, time and channel tag.
// - capture store holds at most 583 entries, reports count and capacity.
// - host clear empties the store, only with automatic readout off.
// - automatic readout streams entries; otherwise they accumulate.
package tcg_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 583;
    localparam int PTR_W = 10;
    localparam int TIME_W = 64;
    localparam int TFOM_W = 4;
    localparam int CHAN_W = 1;
    localparam int ENTRY_W = TIME_W + CHAN_W;
    localparam int NUM_PP = 2;

    // ----------------------------------------------------------------
    // values
    // ----------------------------------------------------------------
    localparam logic [TFOM_W-1:0] TFOM_SYNC = 4'h0;
    localparam logic [PTR_W-1:0] PTR_LAST = 10'h246;
    localparam logic [PTR_W-1:0] CAPACITY = 10'h247;
    localparam logic [PTR_W-1:0] PTR_ZERO = 10'h000;
    localparam logic [CHAN_W-1:0] CHAN_ZERO = 1'h0;

    // programmable output function
    typedef enum logic [1:0] {
        PP_OFF,
        PP_CODE,
        PP_PULSE,
        PP_SYNC
    } tcg_ppfunc_type;
endpackage
